// file: logic/bucd_defines.svh
`ifndef BUCD_DEFINES_SVH
`define BUCD_DEFINES_SVH

// Width of the count and of each limit
`define BUCD_WIDTH      8
// Reset value of the count and of both captured limits
`define BUCD_CNT_RST    8'h00
// Reset level of every synchroniser stage
`define BUCD_SYNC_RST   1'b0
// Count bit whose carry and borrow terms are watched most closely
`define BUCD_WATCH_BIT  2
// Low count bits that feed the watched bit
`define BUCD_LOW_HI     1
`define BUCD_LOW_LO     0
// Low-bit patterns that toggle the watched bit
`define BUCD_LOW_ONES   2'h3
`define BUCD_LOW_ZEROS  2'h0

`endif

// file: logic/bucd_pkg.sv
package bucd_pkg;
  `include "bucd_defines.svh"

  // Counter phase, Gray ordered: preload then count
  typedef enum logic [0:0] {
    BUCD_ST_PRELOAD = 1'b0,
    BUCD_ST_COUNT   = 1'b1
  } bucd_mode_t;

  // Both limit values as driven by the external logic
  typedef struct packed {
    logic [`BUCD_WIDTH-1:0] lower;
    logic [`BUCD_WIDTH-1:0] upper;
  } bucd_limits_t;

  // Whole state of the counter
  typedef struct packed {
    bucd_mode_t             mode;
    logic [`BUCD_WIDTH-1:0] count;
    logic [`BUCD_WIDTH-1:0] lower;
    logic [`BUCD_WIDTH-1:0] upper;
    logic                   up_n;
    logic                   lower_loaded;
    logic                   upper_loaded;
    logic                   lclk_q;
    logic                   uclk_q;
    logic                   oe_q;
  } bucd_state_t;
endpackage

// file: logic/bucd_sync.sv
`timescale 1ns/100ps
`include "bucd_defines.svh"

module bucd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,  // State-register clock
  input  wire logic         reset_n,  // Synchronous reset, active low
  input  wire logic [W-1:0] async_in, // Inputs from outside the clock domain
  output logic      [W-1:0] sync_out  // Filtered, settled levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } bucd_sync_state_t;

  bucd_sync_state_t st_q;
  bucd_sync_state_t st_d;

  // Stage one feeds only stage two; a bit moves once stages two and three agree
  always_comb begin
    st_d      = st_q;
    st_d.s1   = async_in;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.filt = (st_q.s2 & st_q.s3) | (st_q.filt & (st_q.s2 | st_q.s3));
  end

  // Reset clears all stages so no false edge shows after release
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= {$bits(bucd_sync_state_t){`BUCD_SYNC_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.filt;
endmodule

// file: logic/bucd_counter.sv
`timescale 1ns/100ps
`include "bucd_defines.svh"

// Overview of operation
// R1 - Lower limit captured on lower-limit clock rise
// R2 - Upper limit captured on upper-limit clock rise
// R3 - Outside logic preloads both limits first
// R4 - After preload, run from last limit onward
// R5 - Reverse at each limit, bounce continuously
// R6 - Lower preload toggles bits differing from limit
// R7 - Upper preload toggles bits differing from limit
// R8 - Counting up: bit2 toggles when bits0,1 high
// R9 - Counting down: bit2 toggles when bits0,1 low
// R10 - Direction and equality flags are active low
// R11 - Count state on its own state clock
// R12 - Outputs enabled by pin or product term
// R13 - Reset clears count, direction, preload done
// R14 - Count and limits are eight bits wide
module bucd_counter (
  input  wire logic                   clk_sys,               // State-register clock, 100 MHz
  input  wire logic                   reset_n,               // Synchronous reset, active low
  input  wire logic                   lower_limit_clock,     // Lower-limit capture clock pin
  input  wire logic                   upper_limit_clock,     // Upper-limit capture clock pin
  input  wire bucd_pkg::bucd_limits_t limit_in,              // Lower and upper limit values
  input  wire logic                   count_output_enable_n, // Output enable pin, active low
  input  wire logic                   oe_select,             // High: product-term enable
  output logic [`BUCD_WIDTH-1:0]      count_out,             // Count value
  output logic                        count_oe,              // Count outputs driven when high
  output logic                        preload_done           // Both limits loaded
);
  import bucd_pkg::*;

  localparam int W    = `BUCD_WIDTH; // R14
  localparam int SW   = 2 + 2 * W + 1;

  bucd_state_t          st_q;
  bucd_state_t          st_d;
  logic [SW-1:0]        sync_q;
  logic                 lclk_s;
  logic                 uclk_s;
  logic                 oe_pin_s;
  bucd_limits_t         lim_s;
  logic                 edge_l;
  logic                 edge_u;
  logic                 at_upper_limit_n;
  logic                 at_lower_limit_n;
  logic [W-1:0]         tog_up;
  logic [W-1:0]         tog_dn;
  logic [W-1:0]         tog;

  // Limit clocks, limit data and the enable pin all settle through one chain,
  // so data and its clock edge arrive with the same latency.
  // The enable pin enters inverted: its idle level then equals the cleared
  // level of the chain, so no false enable shows in the cycles after reset
  bucd_sync #(
    .W (SW)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({lower_limit_clock, upper_limit_clock, limit_in, ~count_output_enable_n}),
    .sync_out (sync_q)
  );

  assign lclk_s     = sync_q[SW-1];
  assign uclk_s     = sync_q[SW-2];
  assign lim_s      = sync_q[SW-3:1];
  assign oe_pin_s   = sync_q[0];

  // Rising edges of the settled limit clocks
  assign edge_l = lclk_s & ~st_q.lclk_q;
  assign edge_u = uclk_s & ~st_q.uclk_q;

  // Equality flags are low while the count sits on a limit
  assign at_upper_limit_n = (st_q.count != st_q.upper); // R10
  assign at_lower_limit_n = (st_q.count != st_q.lower); // R10

  // Toggle terms of a binary counter built from T flip-flops
  for (genvar i = 0; i < W; i++) begin : g_tog
    if (i == 0) begin : g_lsb
      assign tog_up[i] = 1'b1;
      assign tog_dn[i] = 1'b1;
    end else begin : g_bit
      assign tog_up[i] = &st_q.count[i-1:0];  // R8
      assign tog_dn[i] = ~|st_q.count[i-1:0]; // R9
    end
  end

  // Next state; a preload edge outranks counting in the same cycle
  always_comb begin
    st_d        = st_q;
    tog         = '0;
    st_d.lclk_q = lclk_s;
    st_d.uclk_q = uclk_s;
    if (edge_l) begin
      st_d.lower        = lim_s.lower; // R1
      st_d.lower_loaded = 1'b1;
      tog               = st_q.count ^ lim_s.lower; // R6
    end
    if (edge_u) begin
      st_d.upper        = lim_s.upper; // R2
      st_d.upper_loaded = 1'b1;
      tog               = st_q.count ^ lim_s.upper; // R7
    end
    if (edge_l || edge_u) begin
      // Head away from whichever limit was loaded last
      st_d.up_n = edge_u; // R4
      if (st_d.lower_loaded && st_d.upper_loaded) begin
        st_d.mode = BUCD_ST_COUNT; // R4
      end
    end else if (st_q.mode == BUCD_ST_COUNT) begin
      if (!st_q.up_n) begin
        if (!at_upper_limit_n) begin
          st_d.up_n = 1'b1; // R5
          // Equal limits leave nothing to travel, so the count holds
          tog = at_lower_limit_n ? tog_dn : '0; // R5
        end else begin
          tog = tog_up; // R8
        end
      end else begin
        if (!at_lower_limit_n) begin
          st_d.up_n = 1'b0; // R5
          tog = at_upper_limit_n ? tog_up : '0; // R5
        end else begin
          tog = tog_dn; // R9
        end
      end
    end
    st_d.count = st_q.count ^ tog;
    // Product term keeps outputs off until the count is meaningful
    st_d.oe_q = oe_select ? (st_d.mode == BUCD_ST_COUNT) : oe_pin_s; // R12
  end

  // Count state runs only on the state-register clock
  always_ff @(posedge clk_sys) begin // R11
    if (!reset_n) begin
      st_q.mode         <= BUCD_ST_PRELOAD; // R13
      st_q.count        <= `BUCD_CNT_RST;   // R13
      st_q.lower        <= `BUCD_CNT_RST;
      st_q.upper        <= `BUCD_CNT_RST;
      st_q.up_n         <= 1'b0;            // R13
      st_q.lower_loaded <= 1'b0;
      st_q.upper_loaded <= 1'b0;
      st_q.lclk_q       <= 1'b0;
      st_q.uclk_q       <= 1'b0;
      st_q.oe_q         <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_out    = st_q.count;
  assign count_oe     = st_q.oe_q;
  assign preload_done = (st_q.mode == BUCD_ST_COUNT);

  // Checks on the running design
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic counting_up;
  logic counting_dn;
  assign counting_up = preload_done & ~st_q.up_n & at_upper_limit_n & ~edge_l & ~edge_u;
  assign counting_dn = preload_done & st_q.up_n & at_lower_limit_n & ~edge_l & ~edge_u;

  sequence s_lower_edge;
    edge_l && !edge_u;
  endsequence

  sequence s_lower_loaded_last;
    s_lower_edge ##0 st_q.upper_loaded;
  endsequence

  sequence s_upper_edge;
    edge_u;
  endsequence

  sequence s_run_free;
    preload_done && !edge_l && !edge_u;
  endsequence

  property p_lower_capture;
    edge_l |=> st_q.lower == $past(lim_s.lower);
  endproperty
  a_lower_capture: assert property (p_lower_capture) else $error("lower limit not captured"); // R1

  property p_upper_capture;
    edge_u |=> st_q.upper == $past(lim_s.upper);
  endproperty
  a_upper_capture: assert property (p_upper_capture) else $error("upper limit not captured"); // R2

  property p_lower_preload;
    s_lower_edge |=> count_out == $past(lim_s.lower);
  endproperty
  a_lower_preload: assert property (p_lower_preload) else $error("count not preloaded low"); // R6

  property p_upper_preload;
    edge_u |=> count_out == $past(lim_s.upper);
  endproperty
  a_upper_preload: assert property (p_upper_preload) else $error("count not preloaded high"); // R7

  property p_start_up;
    s_lower_loaded_last |=> preload_done && !st_q.up_n;
  endproperty
  a_start_up: assert property (p_start_up) else $error("count did not start upward"); // R4

  property p_up_carry;
    counting_up && count_out[`BUCD_LOW_HI:`BUCD_LOW_LO] == `BUCD_LOW_ONES
      |=> count_out[`BUCD_WATCH_BIT] != $past(count_out[`BUCD_WATCH_BIT]);
  endproperty
  a_up_carry: assert property (p_up_carry) else $error("bit2 missed carry"); // R8

  property p_dn_borrow;
    counting_dn && count_out[`BUCD_LOW_HI:`BUCD_LOW_LO] == `BUCD_LOW_ZEROS
      |=> count_out[`BUCD_WATCH_BIT] != $past(count_out[`BUCD_WATCH_BIT]);
  endproperty
  a_dn_borrow: assert property (p_dn_borrow) else $error("bit2 missed borrow"); // R9

  property p_reverse;
    preload_done && !st_q.up_n && !at_upper_limit_n && !edge_l && !edge_u
      |=> st_q.up_n && $stable(st_q.upper);
  endproperty
  a_reverse: assert property (p_reverse) else $error("no reversal at upper limit"); // R5

  property p_step_up;
    counting_up |=> count_out == $past(count_out) + 8'h01;
  endproperty
  a_step_up: assert property (p_step_up) else $error("up step wrong"); // R5

  property p_flags;
    s_run_free ##0 (!at_upper_limit_n && at_lower_limit_n)
      |=> count_out == $past(count_out) - 8'h01;
  endproperty
  a_flags: assert property (p_flags) else $error("upper flag did not turn the count"); // R10

  property p_flag_lower;
    s_run_free ##0 (!at_lower_limit_n && at_upper_limit_n)
      |=> count_out == $past(count_out) + 8'h01;
  endproperty
  a_flag_lower: assert property (p_flag_lower) else $error("lower flag did not turn the count"); // R10

  property p_oe;
    oe_select |=> count_oe == preload_done;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable source wrong"); // R12

  property p_oe_pin;
    !oe_select |=> count_oe == $past(oe_pin_s);
  endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("pin enable not followed"); // R12

  property p_step_dn;
    counting_dn |=> count_out == $past(count_out) - 8'h01;
  endproperty
  a_step_dn: assert property (p_step_dn) else $error("down step wrong"); // R9

  property p_reverse_lo;
    preload_done && st_q.up_n && !at_lower_limit_n && !edge_l && !edge_u
      |=> !st_q.up_n && $stable(st_q.lower);
  endproperty
  a_reverse_lo: assert property (p_reverse_lo) else $error("no reversal at lower limit"); // R5

  property p_equal_hold;
    s_run_free ##0 (!at_upper_limit_n && !at_lower_limit_n) |=> $stable(count_out);
  endproperty
  a_equal_hold: assert property (p_equal_hold) else $error("count moved between equal limits"); // R5

  property p_hold_no_load;
    !preload_done && !edge_l && !edge_u |=> $stable(count_out);
  endproperty
  a_hold_no_load: assert property (p_hold_no_load) else $error("count ran before both limits loaded"); // R4

  property p_done_sticky;
    preload_done |=> preload_done;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("preload done dropped while running"); // R4

  property p_done_both;
    preload_done |-> st_q.lower_loaded && st_q.upper_loaded;
  endproperty
  a_done_both: assert property (p_done_both) else $error("counting without both limits"); // R4

  property p_upper_last_down;
    s_upper_edge |=> st_q.up_n;
  endproperty
  a_upper_last_down: assert property (p_upper_last_down) else $error("no down start after upper load"); // R4

  property p_lower_stable;
    !edge_l |=> $stable(st_q.lower);
  endproperty
  a_lower_stable: assert property (p_lower_stable) else $error("lower limit changed without edge"); // R1

  property p_upper_stable;
    !edge_u |=> $stable(st_q.upper);
  endproperty
  a_upper_stable: assert property (p_upper_stable) else $error("upper limit changed without edge"); // R2

  property p_lower_single;
    edge_l |=> !edge_l;
  endproperty
  a_lower_single: assert property (p_lower_single) else $error("lower capture edge too long"); // R1

  property p_upper_single;
    edge_u |=> !edge_u;
  endproperty
  a_upper_single: assert property (p_upper_single) else $error("upper capture edge too long"); // R2

  property p_reset;
    disable iff (1'b0) !reset_n |=> count_out == `BUCD_CNT_RST && !preload_done && !st_q.up_n && !count_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear state"); // R13
endmodule

// file: bench/bucd_limit_src.sv
`timescale 1ns/100ps
`include "bucd_defines.svh"

module bucd_limit_src (
  input  wire logic              clk_sys,           // State-register clock
  output bucd_pkg::bucd_limits_t limit_in,          // Limit values
  output logic                   lower_limit_clock, // Lower capture clock
  output logic                   upper_limit_clock  // Upper capture clock
);
  import bucd_pkg::*;

  // Clocks stand low outside a load
  initial begin
    limit_in          = '0;
    lower_limit_clock = 1'b0;
    upper_limit_clock = 1'b0;
  end

  // Data is held six cycles before the rise and six after the fall, well beyond the synchroniser
  // Afterwards it is inverted, so a late sample cannot look like the old value
  task automatic load(input logic up, input logic [`BUCD_WIDTH-1:0] v);
    @(posedge clk_sys);
    if (up) limit_in.upper <= v;
    else limit_in.lower <= v;
    repeat (6) @(posedge clk_sys);
    if (up) upper_limit_clock <= 1'b1;
    else lower_limit_clock <= 1'b1;
    repeat (6) @(posedge clk_sys);
    upper_limit_clock <= 1'b0;
    lower_limit_clock <= 1'b0;
    repeat (6) @(posedge clk_sys);
    if (up) limit_in.upper <= ~v;
    else limit_in.lower <= ~v;
  endtask
endmodule

// file: bench/tb_bounded_up_down_counter.sv
`timescale 1ns/100ps
`include "bucd_defines.svh"
`define BUCD_CHK(act, exp) check_val((act), (exp))

module tb_bounded_up_down_counter;
  import bucd_pkg::*;
  logic                   clk_sys = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   count_output_enable_n = 1'b1;
  logic                   oe_select = 1'b0;
  logic                   lower_limit_clock;
  logic                   upper_limit_clock;
  bucd_limits_t           limit_in;
  logic [`BUCD_WIDTH-1:0] count_out;
  logic                   count_oe;
  logic                   preload_done;
  int                     num_errors = 0;
  int                     n_compared = 0;
  logic [7:0]             seq [8] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04};

  // 100 MHz state clock
  always #5 clk_sys = ~clk_sys;

  bucd_limit_src bucd_limit_src_inst (
    .clk_sys           (clk_sys),
    .limit_in          (limit_in),
    .lower_limit_clock (lower_limit_clock),
    .upper_limit_clock (upper_limit_clock)
  );

  bucd_counter bucd_counter_inst (
    .clk_sys               (clk_sys),
    .reset_n               (reset_n),
    .lower_limit_clock     (lower_limit_clock),
    .upper_limit_clock     (upper_limit_clock),
    .limit_in              (limit_in),
    .count_output_enable_n (count_output_enable_n),
    .oe_select             (oe_select),
    .count_out             (count_out),
    .count_oe              (count_oe),
    .preload_done          (preload_done)
  );

  // Case inequality, so an unknown never passes
  task automatic check_val(input logic [7:0] a, input logic [7:0] e);
    n_compared++;
    if (a !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, a, e);
    end
  endtask

  // Outputs are sampled on the falling edge, where they have settled
  task automatic wait_count(input logic [7:0] v);
    @(negedge clk_sys);
    for (int i = 0; i < 40 && count_out !== v; i++) @(negedge clk_sys);
    `BUCD_CHK(count_out, v);
  endtask

  task automatic test_reset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    `BUCD_CHK(count_out, 8'h00);
    `BUCD_CHK(preload_done, 1'b0);
    `BUCD_CHK(count_oe, 1'b0);
    repeat (5) @(negedge clk_sys);
    `BUCD_CHK(count_oe, 1'b0);
    `BUCD_CHK(count_out, 8'h00);
    $display("test reset done");
  endtask

  task automatic test_preload();
    @(posedge clk_sys);
    oe_select <= 1'b1;
    bucd_limit_src_inst.load(1'b0, 8'h04);
    wait_count(8'h04);
    `BUCD_CHK(preload_done, 1'b0);
    fork
      bucd_limit_src_inst.load(1'b1, 8'h08);
      begin
        for (int i = 0; i < 20 && preload_done !== 1'b1; i++) @(negedge clk_sys);
        `BUCD_CHK(count_out, 8'h08);
        @(negedge clk_sys);
        `BUCD_CHK(count_out, 8'h07);
      end
    join
    `BUCD_CHK(count_oe, 1'b1);
    $display("test preload done");
  endtask

  // Full round trip between 4 and 8 crosses the carry and borrow into bit 2
  task automatic test_bounce();
    wait_count(8'h04);
    foreach (seq[i]) begin
      @(negedge clk_sys);
      `BUCD_CHK(count_out, seq[i]);
    end
    $display("test bounce done");
  endtask

  // Lower reloaded last while running: jumps there and heads up
  task automatic test_reload();
    fork
      bucd_limit_src_inst.load(1'b0, 8'h02);
      begin
        wait_count(8'h02);
        @(negedge clk_sys);
        `BUCD_CHK(count_out, 8'h03);
      end
    join
    $display("test reload done");
  endtask

  task automatic test_oe();
    @(posedge clk_sys);
    oe_select <= 1'b0;
    count_output_enable_n <= 1'b1;
    repeat (8) @(negedge clk_sys);
    `BUCD_CHK(count_oe, 1'b0);
    @(posedge clk_sys);
    count_output_enable_n <= 1'b0;
    repeat (8) @(negedge clk_sys);
    `BUCD_CHK(count_oe, 1'b1);
    @(posedge clk_sys);
    count_output_enable_n <= 1'b1;
    oe_select <= 1'b1;
    repeat (8) @(negedge clk_sys);
    `BUCD_CHK(count_oe, 1'b1);
    $display("test output enable done");
  endtask

  // Upper reloaded to equal the lower limit: nothing to travel, count holds
  task automatic test_equal();
    bucd_limit_src_inst.load(1'b1, 8'h02);
    wait_count(8'h02);
    repeat (4) @(negedge clk_sys);
    `BUCD_CHK(count_out, 8'h02);
    $display("test equal limits done");
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence; the second reset lands while the count holds at 2 between equal limits
  initial begin
    test_reset();
    test_preload();
    test_bounce();
    test_reload();
    test_oe();
    test_equal();
    test_reset();
    give_verdict();
  end

  // Tests need well under a thousand cycles
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
endmodule
